// [hdl/tpr_ctrl.sv]
/*
 tpr_ctrl: loop play, punch rehearsal, auto and manual punch control.
 Assumes key and footswitch inputs are one-cycle pulses synchronous to
 pclk, and that the transport follows xport_cmd and moves tape_count.
*/
`timescale 1ns/100ps
module tpr_ctrl #(
	parameter int POSTROLL_CYCLES = tpr_pkg::POSTROLL_CYC, // postroll length
	parameter int BLINK_CYCLES = tpr_pkg::BLINK_CYC // half blink period
) (
	input wire logic pclk, // 20 MHz clock
	input wire logic presetn, // async reset
	input wire logic [11:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic key_play, // play key pulse
	input wire logic key_stop, // stop key pulse
	input wire logic key_ffwd, // fast forward pulse
	input wire logic wind_back_key, // rewind key pulse
	input wire logic key_rec, // record key pulse
	input wire logic key_loop, // loop key pulse
	input wire logic seek_point_one_key, // seek point one pulse
	input wire logic seek_point_two_key, // seek point two pulse
	input wire logic key_rehearsal, // rehearsal key pulse
	input wire logic key_auto, // auto punch key pulse
	input wire logic key_clear, // clear key pulse
	input wire logic footswitch, // footswitch pulse
	input wire logic track_armed, // punch track ready
	input wire logic [15:0] tape_count, // live counter
	input wire logic [15:0] memo_one, // stored point one
	input wire logic [15:0] memo_two, // stored point two
	input wire logic memo_one_valid, // point one held
	input wire logic memo_two_valid, // point two held
	output tpr_pkg::tpr_xport_t xport_cmd, // transport command
	output logic rec_gate, // record head on
	output logic monitor_live, // monitor live input
	output logic rehearsal_lamp, // rehearsal lamp
	output logic start_lamp, // start lamp
	output logic in_lamp, // punch-in lamp
	output logic out_lamp, // punch-out lamp
	output logic rec_key_lamp, // lamp over record key
	output logic rec_lamp, // track record lamp
	output logic auto_lamp, // armed lamp
	output logic loop_lamp, // loop lamp
	output logic memo_one_lamp, // point one lamp
	output logic memo_two_lamp // point two lamp
);
	tpr_pkg::tpr_mode_t mode_reg;
	tpr_pkg::tpr_phase_t phase_reg;
	tpr_pkg::tpr_xport_t xport_reg;
	logic [1:0] cap_reg, kind_reg;
	logic [15:0] start_reg, in_reg, out_reg, loc_tgt_reg, prev_reg;
	logic loc_act_reg, loc_play_reg, rpt_reg, auto_steady_reg;
	logic rec_gate_reg, mon_live_reg, memo_flash_reg, memo_dark_reg;
	logic [tpr_pkg::TMR_W-1:0] tmr_reg, blink_cnt_reg;
	logic blink_reg;
	logic [31:0] ctrl_reg, prdata_reg, rd_data;

	// decode of keys and tape position
	wire [11:0] keys = {key_play, key_stop, key_ffwd, wind_back_key, key_rec, key_loop,
		seek_point_one_key, seek_point_two_key, key_rehearsal, key_auto, key_clear,
		footswitch};
	wire foot = footswitch & ctrl_reg[tpr_pkg::CTRL_FOOT_EN];
	wire seek = seek_point_one_key | seek_point_two_key;
	wire playing = xport_reg == tpr_pkg::XP_PLAY;
	wire stopped = xport_reg == tpr_pkg::XP_STOP;
	wire rec_mode = track_armed | rec_gate_reg;
	wire points_ok = memo_one_valid & memo_two_valid;
	wire [15:0] lo = (memo_one < memo_two) ? memo_one : memo_two;
	wire [15:0] hi = (memo_one < memo_two) ? memo_two : memo_one;
	wire span_short = !points_ok || (hi - lo) < tpr_pkg::LOOP_MIN_UNITS;
	wire [15:0] lo_near = (lo > tpr_pkg::LOOP_NEAR_UNITS) ?
		lo - tpr_pkg::LOOP_NEAR_UNITS : tpr_pkg::CNT_ZERO;
	wire in_loop = tape_count >= lo && tape_count <= hi;
	wire near_loop = tape_count >= lo_near && tape_count <= hi;
	wire hit_in = playing && tape_count == in_reg && prev_reg != in_reg;
	wire hit_out = playing && tape_count == out_reg && prev_reg != out_reg;
	wire loc_hit = loc_act_reg && (tape_count == loc_tgt_reg ||
		(xport_reg == tpr_pkg::XP_REW && tape_count < loc_tgt_reg) ||
		(xport_reg == tpr_pkg::XP_FFWD && tape_count > loc_tgt_reg));
	wire tpr_pkg::tpr_xport_t loc_dir = (tape_count < loc_tgt_reg) ?
		tpr_pkg::XP_FFWD : tpr_pkg::XP_REW;
	wire loop_ok = !rec_mode && !span_short;
	wire reh_ok = !loc_act_reg && !rec_gate_reg;

	// free blink phase shared by all flashing lamps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_reg <= '0;
			blink_reg <= 1'b0;
		end else if (blink_cnt_reg == tpr_pkg::TMR_W'(BLINK_CYCLES - 1)) begin
			blink_cnt_reg <= '0;
			blink_reg <= !blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 1'b1;
		end
	end

	// transport, mode and pass sequencer; later assignments win
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= tpr_pkg::MD_IDLE;
			phase_reg <= tpr_pkg::PH_NONE;
			xport_reg <= tpr_pkg::XP_STOP;
			cap_reg <= tpr_pkg::CAP_NONE;
			kind_reg <= tpr_pkg::KD_REH;
			start_reg <= '0;
			in_reg <= '0;
			out_reg <= '0;
			loc_tgt_reg <= '0;
			prev_reg <= '0;
			loc_act_reg <= 1'b0;
			loc_play_reg <= 1'b0;
			rpt_reg <= 1'b0;
			auto_steady_reg <= 1'b0;
			rec_gate_reg <= 1'b0;
			mon_live_reg <= 1'b0;
			memo_flash_reg <= 1'b0;
			memo_dark_reg <= 1'b0;
			tmr_reg <= '0;
		end else begin
			prev_reg <= tape_count;
			if (|keys)
				memo_flash_reg <= 1'b0;
			// locate engine: wind toward target, then play or stop
			if (loc_hit) begin
				loc_act_reg <= 1'b0;
				xport_reg <= loc_play_reg ? tpr_pkg::XP_PLAY : tpr_pkg::XP_STOP;
			end else if (loc_act_reg) begin
				xport_reg <= loc_dir;
			end
			// pass phases shared by rehearsal, auto punch and review
			case (phase_reg)
				tpr_pkg::PH_PLAY: begin
					if (hit_in && kind_reg != tpr_pkg::KD_REV) begin
						mon_live_reg <= 1'b1;
						rec_gate_reg <= kind_reg == tpr_pkg::KD_REC;
					end
					if (hit_out) begin
						mon_live_reg <= 1'b0;
						rec_gate_reg <= 1'b0;
						auto_steady_reg <= kind_reg == tpr_pkg::KD_REC;
						phase_reg <= tpr_pkg::PH_POST;
						tmr_reg <= tpr_pkg::TMR_W'(POSTROLL_CYCLES - 1);
					end
				end
				tpr_pkg::PH_POST: begin
					if (tmr_reg == '0) begin
						phase_reg <= tpr_pkg::PH_HOME;
						loc_act_reg <= 1'b1;
						loc_tgt_reg <= start_reg;
						loc_play_reg <= 1'b0;
					end else begin
						tmr_reg <= tmr_reg - 1'b1;
					end
				end
				tpr_pkg::PH_HOME: begin
					if (loc_hit) begin
						phase_reg <= rpt_reg ? tpr_pkg::PH_PLAY : tpr_pkg::PH_NONE;
						if (rpt_reg)
							xport_reg <= tpr_pkg::XP_PLAY;
						if (mode_reg == tpr_pkg::MD_RH_SETUP)
							mode_reg <= tpr_pkg::MD_RH_READY;
						if (mode_reg == tpr_pkg::MD_AUTO_ARM && kind_reg == tpr_pkg::KD_REC)
							mode_reg <= tpr_pkg::MD_AUTO_DONE;
					end
				end
				default: begin
				end
			endcase
			case (mode_reg)
				tpr_pkg::MD_IDLE, tpr_pkg::MD_LOOP_HOLD: begin
					if (key_loop) begin
						if (rec_mode) begin
						end else if (span_short) begin
							memo_flash_reg <= 1'b1;
						end else begin
							// wind to lower point, then play
							mode_reg <= tpr_pkg::MD_LOOP;
							loc_act_reg <= 1'b1;
							loc_tgt_reg <= lo;
							loc_play_reg <= 1'b1;
						end
					end else if (key_rehearsal && mode_reg == tpr_pkg::MD_IDLE && reh_ok) begin
						mode_reg <= tpr_pkg::MD_RH_SETUP;
						if (playing) begin
							start_reg <= tape_count;
							cap_reg <= tpr_pkg::CAP_START;
						end
					end else if (key_play) begin
						// resume near the loop; punch out
						xport_reg <= tpr_pkg::XP_PLAY;
						loc_act_reg <= 1'b0;
						rec_gate_reg <= 1'b0;
						if (mode_reg == tpr_pkg::MD_LOOP_HOLD && near_loop)
							mode_reg <= tpr_pkg::MD_LOOP;
					end else if (key_stop || key_ffwd || wind_back_key) begin
						xport_reg <= key_stop ? tpr_pkg::XP_STOP :
							key_ffwd ? tpr_pkg::XP_FFWD : tpr_pkg::XP_REW;
						loc_act_reg <= 1'b0;
						rec_gate_reg <= 1'b0;
					end else if ((key_rec || foot) && playing && track_armed
						&& mode_reg == tpr_pkg::MD_IDLE) begin
						rec_gate_reg <= !(foot && rec_gate_reg);
					end else if (seek && mode_reg == tpr_pkg::MD_LOOP_HOLD && !span_short) begin
						mode_reg <= tpr_pkg::MD_LOOP;
						loc_act_reg <= 1'b1;
						loc_tgt_reg <= lo;
						loc_play_reg <= 1'b1;
					end else if (seek) begin
						loc_act_reg <= seek_point_one_key ? memo_one_valid : memo_two_valid;
						loc_tgt_reg <= seek_point_one_key ? memo_one : memo_two;
						loc_play_reg <= 1'b0;
					end else if (key_clear) begin
						mode_reg <= tpr_pkg::MD_IDLE;
					end
				end
				tpr_pkg::MD_LOOP: begin
					// interrupt by any other transport key
					if (key_stop || key_ffwd || wind_back_key) begin
						mode_reg <= tpr_pkg::MD_LOOP_HOLD;
						loc_act_reg <= 1'b0;
						xport_reg <= key_stop ? tpr_pkg::XP_STOP :
							key_ffwd ? tpr_pkg::XP_FFWD : tpr_pkg::XP_REW;
					end else if (playing && !loc_act_reg && tape_count >= hi) begin
						// end reached, back to lower point
						loc_act_reg <= 1'b1;
						loc_tgt_reg <= lo;
						loc_play_reg <= 1'b1;
					end
				end
				tpr_pkg::MD_RH_SETUP: begin
					// loop and seek keys are not decoded here
					if (key_clear) begin
						mode_reg <= tpr_pkg::MD_IDLE;
					end else if (key_play || foot) begin
						if (cap_reg == tpr_pkg::CAP_NONE) begin
							xport_reg <= tpr_pkg::XP_PLAY;
							start_reg <= tape_count;
							cap_reg <= tpr_pkg::CAP_START;
							memo_dark_reg <= 1'b1;
						end else if (cap_reg == tpr_pkg::CAP_START && foot && playing) begin
							in_reg <= tape_count;
							cap_reg <= tpr_pkg::CAP_IN;
						end else if (cap_reg == tpr_pkg::CAP_IN && playing) begin
							out_reg <= tape_count;
							cap_reg <= tpr_pkg::CAP_OUT;
							phase_reg <= tpr_pkg::PH_POST;
							tmr_reg <= tpr_pkg::TMR_W'(POSTROLL_CYCLES - 1);
						end else if (foot && stopped) begin
							loc_act_reg <= 1'b1;
							loc_tgt_reg <= start_reg;
							loc_play_reg <= 1'b0;
						end else if (key_play) begin
							xport_reg <= tpr_pkg::XP_PLAY;
						end
					end else if (key_rec && playing && cap_reg == tpr_pkg::CAP_START) begin
						in_reg <= tape_count;
						cap_reg <= tpr_pkg::CAP_IN;
					end else if (key_stop || key_ffwd) begin
						xport_reg <= key_stop ? tpr_pkg::XP_STOP : tpr_pkg::XP_FFWD;
						loc_act_reg <= 1'b0;
						if (phase_reg == tpr_pkg::PH_POST)
							phase_reg <= tpr_pkg::PH_HOME;
					end else if (wind_back_key) begin
						loc_act_reg <= 1'b1;
						loc_tgt_reg <= start_reg;
						loc_play_reg <= 1'b0;
					end
				end
				default: begin
					// ready, armed and done: points are held, no record key
					if (key_clear) begin
						mode_reg <= tpr_pkg::MD_IDLE;
					end else if (key_auto && mode_reg != tpr_pkg::MD_AUTO_ARM) begin
						mode_reg <= tpr_pkg::MD_AUTO_ARM;
						auto_steady_reg <= 1'b0;
					end else if ((key_play || foot || key_loop) && phase_reg == tpr_pkg::PH_NONE) begin
						// start a pass from start point
						xport_reg <= tpr_pkg::XP_PLAY;
						phase_reg <= tpr_pkg::PH_PLAY;
						rpt_reg <= key_loop && mode_reg == tpr_pkg::MD_RH_READY;
						kind_reg <= mode_reg == tpr_pkg::MD_RH_READY ? tpr_pkg::KD_REH :
							mode_reg == tpr_pkg::MD_AUTO_ARM ? tpr_pkg::KD_REC : tpr_pkg::KD_REV;
						// review after auto punch also holds auto_steady_reg set until out
						if (mode_reg == tpr_pkg::MD_AUTO_DONE)
							auto_steady_reg <= 1'b1;
					end else if (key_stop || (foot && stopped) || wind_back_key) begin
						phase_reg <= tpr_pkg::PH_NONE;
						rpt_reg <= 1'b0;
						mon_live_reg <= 1'b0;
						rec_gate_reg <= 1'b0;
						xport_reg <= tpr_pkg::XP_STOP;
						loc_act_reg <= !key_stop;
						loc_tgt_reg <= start_reg;
						loc_play_reg <= 1'b0;
					end
				end
			endcase
			// clear wipes the stored points and any pass in flight
			if (key_clear && mode_reg >= tpr_pkg::MD_RH_SETUP) begin
				cap_reg <= tpr_pkg::CAP_NONE;
				phase_reg <= tpr_pkg::PH_NONE;
				rpt_reg <= 1'b0;
				mon_live_reg <= 1'b0;
				rec_gate_reg <= 1'b0;
				memo_dark_reg <= 1'b0;
				auto_steady_reg <= 1'b0;
				start_reg <= '0;
				in_reg <= '0;
				out_reg <= '0;
			end
		end
	end

	// lamp selection terms
	wire man_ok = mode_reg <= tpr_pkg::MD_LOOP_HOLD;
	wire lamp_rehearsal_lamp = mode_reg == tpr_pkg::MD_RH_READY ||
		(mode_reg == tpr_pkg::MD_RH_SETUP && blink_reg);
	// armed blink only outside point modes
	wire lamp_rec = rec_gate_reg || (mon_live_reg && blink_reg) ||
		(man_ok && track_armed && blink_reg);
	wire lamp_auto = mode_reg == tpr_pkg::MD_AUTO_DONE ||
		(mode_reg == tpr_pkg::MD_AUTO_ARM && (auto_steady_reg || blink_reg));
	// steady in loop, blinking once outside while held
	wire lamp_loop = mode_reg == tpr_pkg::MD_LOOP ||
		(mode_reg == tpr_pkg::MD_LOOP_HOLD && (in_loop || blink_reg));

	// lamps, registered from mode, capture, gate and memo state and blink phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rehearsal_lamp <= 1'b0;
			start_lamp <= 1'b0;
			in_lamp <= 1'b0;
			out_lamp <= 1'b0;
			rec_key_lamp <= 1'b0;
			rec_lamp <= 1'b0;
			auto_lamp <= 1'b0;
			loop_lamp <= 1'b0;
			memo_one_lamp <= 1'b0;
			memo_two_lamp <= 1'b0;
		end else begin
			rehearsal_lamp <= lamp_rehearsal_lamp;
			start_lamp <= cap_reg != tpr_pkg::CAP_NONE;
			in_lamp <= cap_reg == tpr_pkg::CAP_IN;
			out_lamp <= cap_reg == tpr_pkg::CAP_OUT;
			rec_key_lamp <= cap_reg == tpr_pkg::CAP_IN && blink_reg;
			rec_lamp <= lamp_rec;
			auto_lamp <= lamp_auto;
			loop_lamp <= lamp_loop;
			memo_one_lamp <= memo_flash_reg ? blink_reg : memo_one_valid && !memo_dark_reg;
			memo_two_lamp <= memo_flash_reg ? blink_reg : memo_two_valid && !memo_dark_reg;
		end
	end

	// apb slave: zero wait, read data latched in the setup cycle
	wire addr_ok = paddr == tpr_pkg::ADDR_CTRL || paddr == tpr_pkg::ADDR_STATUS ||
		paddr == tpr_pkg::ADDR_START || paddr == tpr_pkg::ADDR_IN ||
		paddr == tpr_pkg::ADDR_OUT;
	wire apb_wr = psel && penable && pwrite && paddr == tpr_pkg::ADDR_CTRL;
	assign rd_data = paddr == tpr_pkg::ADDR_CTRL ? ctrl_reg :
		paddr == tpr_pkg::ADDR_STATUS ? {18'h00000, rec_gate_reg, mon_live_reg,
			loc_act_reg, kind_reg, phase_reg, cap_reg, mode_reg, xport_reg} :
		paddr == tpr_pkg::ADDR_START ? {16'h0000, start_reg} :
		paddr == tpr_pkg::ADDR_IN ? {16'h0000, in_reg} :
		paddr == tpr_pkg::ADDR_OUT ? {16'h0000, out_reg} : 32'h0000_0000;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_reg;
	assign xport_cmd = xport_reg;
	assign rec_gate = rec_gate_reg;
	assign monitor_live = mon_live_reg;

	// control register and read latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= tpr_pkg::CTRL_RESET;
			prdata_reg <= '0;
		end else begin
			if (apb_wr)
				ctrl_reg <= {31'h0000_0000, pwdata[tpr_pkg::CTRL_FOOT_EN]};
			if (psel && !penable)
				prdata_reg <= rd_data;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire one_key = $onehot(keys);
	chk_loop_rec_refused: assert property (
		mode_reg == tpr_pkg::MD_IDLE && key_loop && rec_mode |=> mode_reg == tpr_pkg::MD_IDLE)
		else $error("loop started in record mode");
	chk_short_loop_flash: assert property (
		mode_reg == tpr_pkg::MD_IDLE && key_loop && !rec_mode && span_short
		|=> memo_flash_reg && mode_reg == tpr_pkg::MD_IDLE ##1 !loop_lamp)
		else $error("short loop not flagged");
	chk_rehearsal_entry: assert property (
		mode_reg == tpr_pkg::MD_IDLE && key_rehearsal && one_key && reh_ok
		|=> mode_reg == tpr_pkg::MD_RH_SETUP)
		else $error("rehearsal setup not entered");
	chk_start_latch: assert property (
		mode_reg == tpr_pkg::MD_RH_SETUP && cap_reg == tpr_pkg::CAP_NONE && key_play && one_key
		|=> start_reg == $past(tape_count) && playing ##1 start_lamp)
		else $error("start point not latched");
	chk_rehearsal_refused: assert property (
		mode_reg == tpr_pkg::MD_LOOP && key_rehearsal |=> mode_reg != tpr_pkg::MD_RH_SETUP)
		else $error("rehearsal entered from loop");
	chk_postroll_home: assert property (
		phase_reg == tpr_pkg::PH_POST && tmr_reg == '0 && !(|keys)
		|=> phase_reg == tpr_pkg::PH_HOME && loc_act_reg && loc_tgt_reg == start_reg)
		else $error("postroll did not rewind home");
	chk_clear_erases: assert property (
		mode_reg >= tpr_pkg::MD_RH_READY && key_clear
		|=> mode_reg == tpr_pkg::MD_IDLE && cap_reg == tpr_pkg::CAP_NONE && start_reg == '0)
		else $error("clear did not erase points");
	chk_stored_no_rec: assert property (
		mode_reg == tpr_pkg::MD_RH_READY |-> !rec_gate_reg)
		else $error("recording with rehearsal points stored");
	chk_rehearse_live: assert property (
		phase_reg == tpr_pkg::PH_PLAY && kind_reg == tpr_pkg::KD_REH && hit_in && !(|keys)
		|=> mon_live_reg && !rec_gate_reg)
		else $error("rehearsal punch-in not live");
	chk_manual_punch: assert property (
		mode_reg == tpr_pkg::MD_IDLE && key_rec && one_key && playing && track_armed
		|=> rec_gate_reg ##1 rec_lamp)
		else $error("manual punch-in failed");
	cov_loop_wrap: cover property (mode_reg == tpr_pkg::MD_LOOP && playing && tape_count >= hi);
	cov_rehearsal_ready: cover property (mode_reg == tpr_pkg::MD_RH_SETUP
		##1 mode_reg == tpr_pkg::MD_RH_READY);
	cov_auto_done: cover property (mode_reg == tpr_pkg::MD_AUTO_ARM
		##1 mode_reg == tpr_pkg::MD_AUTO_DONE);
endmodule : tpr_ctrl

// [pkg/tpr_pkg.sv]
/*
 tpr_pkg: constants, states and register map of the tape punch and
 loop transport controller. Assumes a 20 MHz pclk and a 16-bit tape
 counter in counter units.
*/
// Operation
// - non-play transport key interrupts loop; lamp blinks once tape leaves loop
// - seek-point key, or play inside or just before loop, resumes the loop
// - loop refused while track armed or recording
// - points closer than 0003 units: loop lamp off, memo lamps flash
// - rehearsal key enters setup, rehearsal lamp blinks
// - play in setup starts tape, latches start, start lamp on, memo lamps dark
// - record while playing in setup latches punch-in, in lamp, record-key lamp flashes
// - play after punch-in latches punch-out, out lamp on, in and key lamps off
// - after punch-out, 3 s postroll, rewind to start, rehearsal lamp steady
// - rehearsal pass at punch-in: monitor goes live, record lamp blinks, no recording
// - rehearsal pass at punch-out: monitor tape, lamp off, 3 s postroll, home
// - clear leaves rehearsal, lamp off, erases start, in and out points
// - rehearsal key while playing latches start point at once
// - footswitch latches points; after stop it rewinds to start
// - rehearsal refused while locating, looping or recording
// - locate and loop refused while punch points are captured
// - with punch points held, normal record mode is never entered
// - transport keys work during capture; wind back returns to start and stops
// - auto key arms, auto lamp blinks; play runs whole punch, lamp steady at out
// - play or footswitch reviews insert; auto key re-arms and lamp blinks
// - clear cancels auto mode, erases points, auto lamp off
// - manual punch: record while playing armed records; play ends it
// - lower stored point starts loop, higher ends it, rewind at end
package tpr_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] LOOP_MIN_UNITS = 16'h0003;
	localparam logic [15:0] LOOP_NEAR_UNITS = 16'h0005;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam int CLK_HZ = 20000000;
	localparam int POSTROLL_MS = 3000;
	localparam int BLINK_MS = 250;
	// least times, whole milliseconds give exact cycle counts
	localparam int POSTROLL_CYC = POSTROLL_MS * (CLK_HZ / 1000);
	localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 26;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_START = 12'h008;
	localparam logic [11:0] ADDR_IN = 12'h00c;
	localparam logic [11:0] ADDR_OUT = 12'h010;
	localparam int CTRL_FOOT_EN = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [1:0] CAP_NONE = 2'h0;
	localparam logic [1:0] CAP_START = 2'h1;
	localparam logic [1:0] CAP_IN = 2'h2;
	localparam logic [1:0] CAP_OUT = 2'h3;
	localparam logic [1:0] KD_REH = 2'h0;
	localparam logic [1:0] KD_REC = 2'h1;
	localparam logic [1:0] KD_REV = 2'h2;
	typedef enum logic [1:0] {
		XP_STOP = 2'b00,
		XP_PLAY = 2'b01,
		XP_FFWD = 2'b10,
		XP_REW = 2'b11
	} tpr_xport_t;
	typedef enum logic [2:0] {
		MD_IDLE = 3'b000,
		MD_LOOP = 3'b001,
		MD_LOOP_HOLD = 3'b010,
		MD_RH_SETUP = 3'b011,
		MD_RH_READY = 3'b100,
		MD_AUTO_ARM = 3'b101,
		MD_AUTO_DONE = 3'b110
	} tpr_mode_t;
	typedef enum logic [1:0] {
		PH_NONE = 2'b00,
		PH_PLAY = 2'b01,
		PH_POST = 2'b10,
		PH_HOME = 2'b11
	} tpr_phase_t;
endpackage : tpr_pkg

// [dv/tpr_tape_model.sv]
/*
 tpr_tape_model: behavioural tape transport standing in for the deck.
 Assumes the controller's xport_cmd; play moves one unit a cycle.
*/
`timescale 1ns/100ps
module tpr_tape_model (
	input wire logic pclk, // bench clock
	input wire logic presetn, // async reset
	input wire tpr_pkg::tpr_xport_t xport_cmd, // transport command
	output logic [15:0] tape_count // live counter
);
	// winds move four units, so a locate may overshoot its target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tape_count <= 16'h0100;
		end else begin
			case (xport_cmd)
				tpr_pkg::XP_PLAY: tape_count <= tape_count + 16'h0001;
				tpr_pkg::XP_FFWD: tape_count <= tape_count + 16'h0004;
				tpr_pkg::XP_REW: tape_count <= tape_count - 16'h0004;
				default: tape_count <= tape_count;
			endcase
		end
	end
endmodule : tpr_tape_model

// [dv/tpr_ctrl_tb.sv]
/*
 tpr_ctrl_tb: self-checking bench for the loop and punch controller.
 Assumes tpr_tape_model moves the counter; keys are one-cycle pulses.
*/
`timescale 1ns/100ps
module tpr_ctrl_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic track_armed = 1'b0, v1 = 1'b0, v2 = 1'b0, s1, er;
	logic [11:0] paddr = 12'h000, k = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rec_gate, monitor_live;
	logic [15:0] tape_count, m1 = 16'h0, m2 = 16'h0, hit, st, pin, pout, a;
	logic [9:0] lamps;
	logic [1:0] s;
	tpr_pkg::tpr_xport_t xport_cmd;
	int miscompares = 0, comparisons = 0, cycles = 0, seed = 2936, n;
	tpr_ctrl #(.POSTROLL_CYCLES(50), .BLINK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .key_play(k[0]), .key_stop(k[1]),
		.key_ffwd(k[2]), .wind_back_key(k[3]), .key_rec(k[4]), .key_loop(k[5]),
		.seek_point_one_key(k[6]), .seek_point_two_key(k[7]), .key_rehearsal(k[8]),
		.key_auto(k[9]), .key_clear(k[10]), .footswitch(k[11]), .track_armed(track_armed),
		.tape_count(tape_count), .memo_one(m1), .memo_two(m2), .memo_one_valid(v1),
		.memo_two_valid(v2), .xport_cmd(xport_cmd), .rec_gate(rec_gate),
		.monitor_live(monitor_live), .rehearsal_lamp(lamps[0]), .start_lamp(lamps[1]),
		.in_lamp(lamps[2]), .out_lamp(lamps[3]), .rec_key_lamp(lamps[4]), .rec_lamp(lamps[5]),
		.auto_lamp(lamps[6]), .loop_lamp(lamps[7]), .memo_one_lamp(lamps[8]),
		.memo_two_lamp(lamps[9]));
	tpr_tape_model tape (.pclk(pclk), .presetn(presetn), .xport_cmd(xport_cmd),
		.tape_count(tape_count));
	// clock and hang guard
	initial forever #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask : cyc
	// held until pready is seen at a rising edge, then released
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// key pulse; hit is the count seen with the key
	task automatic press(input int i);
		@(posedge pclk) k[i] <= 1'b1;
		@(posedge pclk) k[i] <= 1'b0;
		hit = tape_count;
		cyc(2);
	endtask : press
	task automatic watch(input int i);
		s = 2'b00;
		repeat (12) begin
			cyc(1);
			s = s | {lamps[i], ~lamps[i]};
		end
	endtask : watch
	// sel 1 waits on the monitor, otherwise on the transport
	task automatic await(input logic sel, input logic [1:0] v);
		for (n = 0; n < 600 && (sel ? {1'b0, monitor_live} : xport_cmd) !== v; n++) cyc(1);
		check(n < 600, 1'b1);
	endtask : await
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, 12'h0ff, 32'h5);
		check(er, 1'b1);
		// short loops with random spacing below the minimum
		repeat (3) begin
			a = 16'h0200 + ($random(seed) & 16'h00ff);
			@(posedge pclk) {m1, m2, v1, v2} <= {a, a + 16'($unsigned($random(seed)) % 3), 2'b11};
			press(5);
			check(xport_cmd, tpr_pkg::XP_STOP);
			watch(8);
			check({s, lamps[7]}, 3'b110);
			press(10);
		end
		@(posedge pclk) {m1, m2, track_armed} <= {a + 16'h0040, a, 1'b1};
		press(5);
		check({xport_cmd, lamps[7]}, 3'b000);
		@(posedge pclk) track_armed <= 1'b0;
		press(8);
		watch(0);
		check(s, 2'b11);
		press(0);
		st = hit;
		check({xport_cmd, lamps[1], lamps[9:8]}, 5'b01100);
		press(4);
		pin = hit;
		check(lamps[2], 1'b1);
		watch(4);
		check(s, 2'b11);
		press(0);
		pout = hit;
		check(lamps[4:2], 3'b010);
		apb(1'b0, 12'h008, 32'h0);
		check(rd, {16'h0, st});
		apb(1'b0, 12'h00c, 32'h0);
		check(rd, {16'h0, pin});
		apb(1'b0, 12'h010, 32'h0);
		check(rd, {16'h0, pout});
		await(1'b0, tpr_pkg::XP_REW);
		await(1'b0, tpr_pkg::XP_STOP);
		check(tape_count <= st, 1'b1);
		watch(0);
		check(s, 2'b10);
		press(0);
		await(1'b1, 2'b01);
		check(rec_gate, 1'b0);
		watch(5);
		check(s, 2'b11);
		await(1'b1, 2'b00);
		cyc(2);
		check(lamps[5], 1'b0);
		await(1'b0, tpr_pkg::XP_STOP);
		check(tape_count <= st, 1'b1);
		// auto punch, review, then re-arm
		press(9);
		check(lamps[0], 1'b0);
		watch(6);
		check(s, 2'b11);
		press(0);
		await(1'b1, 2'b01);
		check(rec_gate, 1'b1);
		await(1'b1, 2'b00);
		cyc(2);
		check({lamps[6], rec_gate}, 2'b10);
		await(1'b0, tpr_pkg::XP_STOP);
		watch(6);
		check(s, 2'b10);
		press(0);
		await(1'b0, tpr_pkg::XP_REW);
		check(monitor_live, 1'b0);
		await(1'b0, tpr_pkg::XP_STOP);
		check(tape_count <= st, 1'b1);
		press(9);
		watch(6);
		check(s, 2'b11);
		press(10);
		check(lamps[0], 1'b0);
		check(lamps[6], 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		check(rd, 32'h0);
		@(posedge pclk) track_armed <= 1'b1;
		press(0);
		press(4);
		check(rec_gate, 1'b1);
		press(0);
		check(rec_gate, 1'b0);
		press(1);
		@(posedge pclk) track_armed <= 1'b0;
		// points given high first: the lower one still starts the loop
		press(5);
		await(1'b0, tpr_pkg::XP_PLAY);
		check(tape_count - a < 16'h0008, 1'b1);
		await(1'b0, tpr_pkg::XP_REW);
		check(tape_count >= a + 16'h0040, 1'b1);
		press(1);
		check(xport_cmd, tpr_pkg::XP_STOP);
		press(6);
		check(xport_cmd != tpr_pkg::XP_STOP, 1'b1);
		report_and_stop();
	end
endmodule : tpr_ctrl_tb
